// ==== verilog/err_steer_pkg.sv ====
// Constants, field layouts and carrier types for the error steering block
package err_steer_pkg;

  // Register byte offsets in configuration space
  localparam logic [11:0] OFF_STEER = 12'h148;
  localparam logic [11:0] OFF_UNC_MASK = 12'h14C;
  localparam logic [11:0] OFF_COR_MASK = 12'h150;

  // Reset values
  localparam logic [31:0] STEER_RESET = 32'h0000_0000;
  localparam logic [31:0] UNC_MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] COR_MASK_RESET = 32'h0000_0000;

  // Writable bits: unsupported req 20, malformed 18..poisoned 12, DL proto 4
  localparam logic [31:0] UNC_MASK_WMASK = 32'h0017_F010;
  localparam logic [31:0] COR_MASK_WMASK = 32'h0000_11C1;
  // Steering: sticky pointer 20:16, plain bits 15:8 and 5:0
  localparam logic [31:0] STEER_STICKY_WMASK = 32'h001F_0000;
  localparam logic [31:0] STEER_PLAIN_WMASK = 32'h0000_FF3F;

  // Steering field positions
  localparam int COR_PTR_LSB = 24;
  localparam int HDR_LOG_BIT = 15;
  localparam int UNIT_EN_BIT = 14;
  localparam int UNIT_FATAL_LSB = 12;
  localparam int UNIT_NONFATAL_LSB = 10;
  localparam int UNIT_COR_LSB = 8;
  localparam int HIER_FATAL_LSB = 4;
  localparam int HIER_NONFATAL_LSB = 2;
  localparam int HIER_COR_LSB = 0;
  localparam int UNIT_PTR_LSB = 16;
  localparam int PTR_W = 5;

  // Root port control enable bits
  localparam int RPC_FATAL_BIT = 2;
  localparam int RPC_NONFATAL_BIT = 1;
  localparam int RPC_COR_BIT = 0;

  // Number of steered report sources
  localparam int NUM_SRC = 6;

  // Steering codes; the code is also the bit index in sys_signal_t
  localparam logic [1:0] SEL_ACPI = 2'h0;
  localparam logic [1:0] SEL_SMI = 2'h1;
  localparam logic [1:0] SEL_SERR = 2'h2;
  localparam logic [1:0] SEL_MCE = 2'h3;

  typedef struct packed {
    logic machine_check_error;
    logic serr;
    logic system_management_interrupt;
    logic acpi_event;
  } sys_signal_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } cfg_rsp_t;

  typedef struct packed {
    logic [31:0] mask_r;
  } sticky_state_t;

  typedef struct packed {
    logic [31:0] steer_r;
    cfg_rsp_t rsp_r;
    sys_signal_t signal_r;
    logic [31:0] unc_log_r;
    logic [31:0] cor_log_r;
  } top_state_t;

  // Expands byte enables to a bit mask
  function automatic logic [31:0] be_bits(input logic [3:0] be);
    be_bits = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_bits

  // One-hot decode of a steering code
  function automatic logic [3:0] sel_onehot(input logic [1:0] sel);
    sel_onehot = 4'h1 << sel;
  endfunction : sel_onehot

endpackage : err_steer_pkg

// ==== verilog/sticky_mask_reg.sv ====
// Register bits that only a power-on reset clears
`timescale 1ns/10ps
module sticky_mask_reg
  import err_steer_pkg::*;
#(
  parameter logic [31:0] WMASK = 32'hFFFF_FFFF,
  parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
  input wire logic clk,
  input wire logic pwr_on_resetn,
  input wire logic wr_en,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  output logic [31:0] value
);

  sticky_state_t st_r;
  sticky_state_t st_nxt;

  // Byte-enabled write of the writable bits only
  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      st_nxt.mask_r = (st_r.mask_r & ~(WMASK & be_bits(be)))
                    | (wdata & WMASK & be_bits(be));
    end
  end

  // System reset is not wired here, so bits survive it
  always_ff @(posedge clk or negedge pwr_on_resetn) begin
    if (!pwr_on_resetn) begin
      st_r <= '{mask_r: RESET_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign value = st_r.mask_r & WMASK;

endmodule : sticky_mask_reg

// ==== verilog/report_router.sv ====
// Steers one error report onto one of four system signals
`timescale 1ns/10ps
module report_router
  import err_steer_pkg::*;
(
  input wire logic event_in,
  input wire logic enable,
  input wire logic [1:0] sel,
  output logic [3:0] route
);

  // Nothing leaves when the path is disabled
  always_comb begin
    route = 4'h0;
    if (event_in && enable) begin
      route = sel_onehot(sel);
    end
  end

endmodule : report_router

// ==== verilog/pcie_error_steer_and_detect_mask.sv ====
// Error report steering and uncorrectable and correctable detect mask registers
`timescale 1ns/10ps
module pcie_error_steer_and_detect_mask
  import err_steer_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic pwr_on_resetn,
  input cfg_req_t cfg_in,
  output cfg_rsp_t cfg_out,
  input wire logic [2:0] root_port_control,
  input sys_signal_t host_signal_enable,
  input wire logic unit_fatal,
  input wire logic unit_nonfatal,
  input wire logic unit_cor,
  input wire logic msg_fatal,
  input wire logic msg_nonfatal,
  input wire logic msg_cor,
  input wire logic [31:0] unc_err_detect,
  input wire logic [31:0] unc_err_fatal_sev,
  input wire logic [31:0] cor_err_detect,
  input wire logic [4:0] cor_first_err_ptr,
  output logic [31:0] unc_err_log_en,
  output logic [31:0] cor_err_log_en,
  output sys_signal_t sys_signal,
  output logic hdr_log_lle_en,
  output logic [4:0] unit_first_err_ptr,
  output logic [31:0] unc_err_mask,
  output logic [31:0] cor_err_mask
);

  top_state_t st_r;
  top_state_t st_nxt;

  // Address decode of the three registers
  logic hit_steer;
  logic hit_unc;
  logic hit_cor;
  logic wr_steer;
  logic wr_unc;
  logic wr_cor;

  always_comb begin
    hit_steer = cfg_in.addr == OFF_STEER;
    hit_unc = cfg_in.addr == OFF_UNC_MASK;
    hit_cor = cfg_in.addr == OFF_COR_MASK;
    wr_steer = cfg_in.req && cfg_in.wr && hit_steer;
    wr_unc = cfg_in.req && cfg_in.wr && hit_unc;
    wr_cor = cfg_in.req && cfg_in.wr && hit_cor;
  end

  // Power-on-only storage: both detect masks and the unit pointer
  logic [31:0] unc_mask_val;
  logic [31:0] cor_mask_val;
  logic [31:0] steer_sticky_val;

  sticky_mask_reg #(
    .WMASK(UNC_MASK_WMASK),
    .RESET_VAL(UNC_MASK_RESET)
  ) u_unc_mask (
    .clk(clk),
    .pwr_on_resetn(pwr_on_resetn),
    .wr_en(wr_unc),
    .be(cfg_in.be),
    .wdata(cfg_in.wdata),
    .value(unc_mask_val)
  );

  sticky_mask_reg #(
    .WMASK(COR_MASK_WMASK),
    .RESET_VAL(COR_MASK_RESET)
  ) u_cor_mask (
    .clk(clk),
    .pwr_on_resetn(pwr_on_resetn),
    .wr_en(wr_cor),
    .be(cfg_in.be),
    .wdata(cfg_in.wdata),
    .value(cor_mask_val)
  );

  sticky_mask_reg #(
    .WMASK(STEER_STICKY_WMASK),
    .RESET_VAL(STEER_RESET)
  ) u_steer_sticky (
    .clk(clk),
    .pwr_on_resetn(pwr_on_resetn),
    .wr_en(wr_steer),
    .be(cfg_in.be),
    .wdata(cfg_in.wdata),
    .value(steer_sticky_val)
  );

  // Full steering word as software sees it
  logic [31:0] steer_val;

  always_comb begin
    steer_val = (st_r.steer_r & STEER_PLAIN_WMASK)
              | steer_sticky_val;
    steer_val[COR_PTR_LSB +: PTR_W] = cor_first_err_ptr;
  end

  // Mask filter on the detect strobes; a set bit blocks its error
  logic [31:0] unc_unmasked;
  logic [31:0] cor_unmasked;

  always_comb begin
    // Bits 20, 18..12 and 4 are held; 19, 0 and reserved stay open
    unc_unmasked = unc_err_detect & ~unc_mask_val;
    unc_unmasked[18] = unc_err_detect[18] & ~unc_mask_val[18];
    unc_unmasked[17] = unc_err_detect[17] & ~unc_mask_val[17];
    unc_unmasked[16] = unc_err_detect[16] & ~unc_mask_val[16];
    unc_unmasked[15] = unc_err_detect[15] & ~unc_mask_val[15];
    unc_unmasked[14] = unc_err_detect[14] & ~unc_mask_val[14];
    unc_unmasked[13] = unc_err_detect[13] & ~unc_mask_val[13];
    unc_unmasked[12] = unc_err_detect[12] & ~unc_mask_val[12];
    unc_unmasked[4] = unc_err_detect[4] & ~unc_mask_val[4];
    cor_unmasked = cor_err_detect & ~cor_mask_val;
  end

  // Hierarchy events: internal unmasked detection or a received message
  logic hier_fatal;
  logic hier_nonfatal;
  logic hier_cor;

  always_comb begin
    hier_fatal = msg_fatal
               || |(unc_unmasked & unc_err_fatal_sev);
    hier_nonfatal = msg_nonfatal
                  || |(unc_unmasked & ~unc_err_fatal_sev);
    hier_cor = msg_cor || |cor_unmasked;
  end

  // Source table for the six steered report paths
  logic [NUM_SRC-1:0] src_event;
  logic [NUM_SRC-1:0] src_en;
  logic [1:0] src_sel [NUM_SRC];
  logic [3:0] src_route [NUM_SRC];

  always_comb begin
    // Unit errors all share one enable
    src_event[0] = unit_fatal;
    src_en[0] = steer_val[UNIT_EN_BIT];
    src_sel[0] = steer_val[UNIT_FATAL_LSB +: 2];
    src_event[1] = unit_nonfatal;
    src_en[1] = steer_val[UNIT_EN_BIT];
    src_sel[1] = steer_val[UNIT_NONFATAL_LSB +: 2];
    src_event[2] = unit_cor;
    src_en[2] = steer_val[UNIT_EN_BIT];
    src_sel[2] = steer_val[UNIT_COR_LSB +: 2];
    // Hierarchy errors each have their own root port enable
    src_event[3] = hier_fatal;
    src_en[3] = root_port_control[RPC_FATAL_BIT];
    src_sel[3] = steer_val[HIER_FATAL_LSB +: 2];
    src_event[4] = hier_nonfatal;
    src_en[4] = root_port_control[RPC_NONFATAL_BIT];
    src_sel[4] = steer_val[HIER_NONFATAL_LSB +: 2];
    src_event[5] = hier_cor;
    src_en[5] = root_port_control[RPC_COR_BIT];
    src_sel[5] = steer_val[HIER_COR_LSB +: 2];
  end

  // One router per source
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_route
      report_router u_router (
        .event_in(src_event[gi]),
        .enable(src_en[gi]),
        .sel(src_sel[gi]),
        .route(src_route[gi])
      );
    end
  endgenerate

  // Merge all routed reports; bit index equals steering code
  logic [3:0] routed;

  always_comb begin
    routed = 4'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      routed = routed | src_route[i];
    end
  end

  // Read data mux; unmapped offsets read zero
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_steer) begin
      rd_val = steer_val;
    end else if (hit_unc) begin
      rd_val = unc_mask_val;
    end else if (hit_cor) begin
      rd_val = cor_mask_val;
    end
  end

  // Next-state: plain steering bits, bus answer, registered outputs
  always_comb begin
    st_nxt = st_r;
    if (wr_steer) begin
      st_nxt.steer_r = (st_r.steer_r & ~(STEER_PLAIN_WMASK
                                          & be_bits(cfg_in.be)))
                     | (cfg_in.wdata & STEER_PLAIN_WMASK
                        & be_bits(cfg_in.be));
    end
    st_nxt.rsp_r.ack = cfg_in.req;
    st_nxt.rsp_r.rdata = 32'h0000_0000;
    if (cfg_in.req && !cfg_in.wr) begin
      st_nxt.rsp_r.rdata = rd_val;
    end
    // System signal pulses, further gated by the host enables
    st_nxt.signal_r = routed & host_signal_enable;
    // Status-log enables only for unmasked errors
    st_nxt.unc_log_r = unc_unmasked;
    st_nxt.cor_log_r = cor_unmasked;
  end

  // State register on system reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{steer_r: STEER_RESET,
                rsp_r: '{ack: 1'b0, rdata: 32'h0000_0000},
                signal_r: 4'h0,
                unc_log_r: 32'h0000_0000,
                cor_log_r: 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Output drive
  assign cfg_out = st_r.rsp_r;
  assign sys_signal = st_r.signal_r;
  assign unc_err_log_en = st_r.unc_log_r;
  assign cor_err_log_en = st_r.cor_log_r;
  assign hdr_log_lle_en = st_r.steer_r[HDR_LOG_BIT];
  assign unit_first_err_ptr = steer_sticky_val[UNIT_PTR_LSB +: PTR_W];
  assign unc_err_mask = unc_mask_val;
  assign cor_err_mask = cor_mask_val;

endmodule : pcie_error_steer_and_detect_mask

// ==== sim/err_steer_props.sv ====
// Checker on the ports of the error steering and detect mask block
`timescale 1ns/10ps
module err_steer_props
  import err_steer_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic pwr_on_resetn,
  input cfg_req_t cfg_in,
  input cfg_rsp_t cfg_out,
  input wire logic [2:0] root_port_control,
  input sys_signal_t host_signal_enable,
  input wire logic unit_fatal,
  input wire logic unit_nonfatal,
  input wire logic unit_cor,
  input wire logic msg_fatal,
  input wire logic msg_nonfatal,
  input wire logic msg_cor,
  input wire logic [31:0] unc_err_detect,
  input wire logic [31:0] cor_err_detect,
  input wire logic [31:0] unc_err_log_en,
  input sys_signal_t sys_signal,
  input wire logic [31:0] unc_err_mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Access and source patterns
  sequence s_wr_mask;
    cfg_in.req && cfg_in.wr && cfg_in.addr == OFF_UNC_MASK
      && cfg_in.be == 4'hF;
  endsequence
  sequence s_rd_mask;
    cfg_in.req && !cfg_in.wr && cfg_in.addr == OFF_UNC_MASK;
  endsequence
  sequence s_no_unit;
    !(unit_fatal | unit_nonfatal | unit_cor) && unc_err_detect == 32'h0
      && cor_err_detect == 32'h0;
  endsequence
  sequence s_msg_off;
    s_no_unit ##0 root_port_control == 3'h0;
  endsequence
  sequence s_quiet;
    s_no_unit ##0 !(msg_fatal | msg_nonfatal | msg_cor);
  endsequence
  a_mask_write: assert property (s_wr_mask |=>
    unc_err_mask == ($past(cfg_in.wdata) & UNC_MASK_WMASK))
    else $error("mask write value wrong");
  a_mask_read: assert property (s_rd_mask |=> cfg_out.ack
    && cfg_out.rdata == $past(unc_err_mask))
    else $error("mask read value wrong");
  a_ro_bits: assert property ((unc_err_mask & ~UNC_MASK_WMASK) == 0)
    else $error("fixed mask bit set");
  a_log_masked: assert property (1'b1 |=>
    unc_err_log_en == ($past(unc_err_detect) & ~$past(unc_err_mask)))
    else $error("log enable ignores mask");
  a_quiet_sig: assert property (s_quiet |=> 4'(sys_signal) == 4'h0)
    else $error("report without source");
  a_hier_gate: assert property (s_msg_off |=> 4'(sys_signal) == 4'h0)
    else $error("hierarchy report while disabled");
  a_host_gate: assert property
    ((4'(sys_signal) & ~4'($past(host_signal_enable))) == 4'h0)
    else $error("report on disabled signal");
  a_mask_stick: assert property (@(posedge clk) disable iff
    (!pwr_on_resetn) !resetn |=> $stable(unc_err_mask))
    else $error("mask lost in reset");
endmodule : err_steer_props

bind pcie_error_steer_and_detect_mask err_steer_props u_props (
  .clk, .resetn, .pwr_on_resetn, .cfg_in, .cfg_out, .root_port_control,
  .host_signal_enable, .unit_fatal, .unit_nonfatal, .unit_cor, .msg_fatal,
  .msg_nonfatal, .msg_cor, .unc_err_detect, .cor_err_detect,
  .unc_err_log_en, .sys_signal, .unc_err_mask);

// ==== sim/sys_event_sink.sv ====
// Model of the system event logic that takes the steered reports
`timescale 1ns/10ps
module sys_event_sink
  import err_steer_pkg::*;
(
  input wire logic clk,
  input wire logic pwr_on_resetn,
  input sys_signal_t sig,
  output logic [15:0] seen
);
  // Counts every report pulse on any of the four signals
  always_ff @(posedge clk or negedge pwr_on_resetn) begin
    if (!pwr_on_resetn) begin
      seen <= 16'h0;
    end else begin
      seen <= seen + 16'($countones(sig));
    end
  end
endmodule : sys_event_sink

// ==== sim/tb_pcie_error_steer_and_detect_mask.sv ====
// Testbench for the error steering and detect mask block
`timescale 1ns/10ps
module tb_pcie_error_steer_and_detect_mask
  import err_steer_pkg::*;
;
  logic clk, resetn, pwr_on_resetn;
  cfg_req_t cfg_in;
  cfg_rsp_t cfg_out;
  logic [2:0] root_port_control;
  sys_signal_t host_signal_enable, sys_signal;
  logic [5:0] src;
  logic [31:0] unc_err_detect, unc_err_fatal_sev, cor_err_detect;
  logic [31:0] unc_err_log_en, cor_err_log_en, unc_err_mask, cor_err_mask;
  logic [31:0] cor_lg;
  logic [3:0] be_cur;
  logic [4:0] unit_first_err_ptr;
  logic hdr_log_lle_en;
  logic [15:0] seen;
  int err_total, checked, exp_pulses;
  pcie_error_steer_and_detect_mask dut (
    .clk, .resetn, .pwr_on_resetn, .cfg_in, .cfg_out, .root_port_control,
    .host_signal_enable, .unit_fatal(src[0]), .unit_nonfatal(src[1]),
    .unit_cor(src[2]), .msg_fatal(src[3]), .msg_nonfatal(src[4]),
    .msg_cor(src[5]), .unc_err_detect, .unc_err_fatal_sev, .cor_err_detect,
    .cor_first_err_ptr(5'h0A), .unc_err_log_en, .cor_err_log_en,
    .sys_signal, .hdr_log_lle_en, .unit_first_err_ptr, .unc_err_mask,
    .cor_err_mask);
  sys_event_sink sink (.clk, .pwr_on_resetn, .sig(sys_signal), .seen);
  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Compare of one value
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // One register access, request for one cycle, answer read mid-cycle
  task automatic cfg(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk);
    cfg_in <= '{1'b1, wr, a, be_cur, d};
    @(posedge clk);
    cfg_in.req <= 1'b0;
    @(negedge clk);
    rd = cfg_out.rdata;
    chk("ack", 32'h1, {31'h0, cfg_out.ack});
    @(posedge clk);
  endtask : cfg
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    cfg(1'b1, a, d, v);
  endtask : wr
  task automatic rchk(input string n, input logic [11:0] a,
                      input logic [31:0] e);
    logic [31:0] v;
    cfg(1'b0, a, 32'h0, v);
    chk(n, e, v);
  endtask : rchk
  // Raises error sources for one cycle and judges the report
  task automatic fire(input logic [5:0] s, input logic [31:0] ue,
                      input logic [31:0] ce, input logic [3:0] e,
                      output logic [31:0] lg);
    @(posedge clk);
    src <= s;
    unc_err_detect <= ue;
    cor_err_detect <= ce;
    @(posedge clk);
    src <= 6'h0;
    unc_err_detect <= 32'h0;
    cor_err_detect <= 32'h0;
    @(negedge clk);
    lg = unc_err_log_en;
    cor_lg = cor_err_log_en;
    chk("sys_signal", {28'h0, e}, {28'h0, 4'(sys_signal)});
    exp_pulses += $countones(e);
    @(posedge clk);
  endtask : fire
  task automatic t_reset();
    rchk("steer", OFF_STEER, 32'h0A00_0000);
    rchk("unc mask", OFF_UNC_MASK, 32'h0);
    rchk("cor mask", OFF_COR_MASK, 32'h0);
    rchk("unmapped", 12'h200, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_mask();
    int b[9] = '{20, 18, 17, 16, 15, 14, 13, 12, 4};
    logic [31:0] m, lg;
    wr(OFF_UNC_MASK, 32'hFFFF_FFFF);
    rchk("mask all", OFF_UNC_MASK, 32'h0017_F010);
    be_cur = 4'h2;
    wr(OFF_UNC_MASK, 32'h0);
    be_cur = 4'hF;
    rchk("mask byte", OFF_UNC_MASK, 32'h0017_0010);
    foreach (b[i]) begin
      m = 32'h1 << b[i];
      wr(OFF_UNC_MASK, m);
      chk("unc mask port", m, unc_err_mask);
      fire(6'h0, 32'hFFFF_FFFF, 32'h0, 4'h0, lg);
      chk("log", ~m, lg);
    end
    wr(OFF_COR_MASK, 32'hFFFF_FFFF);
    rchk("cor mask all", OFF_COR_MASK, 32'h0000_11C1);
    chk("cor mask port", 32'h0000_11C1, cor_err_mask);
    fire(6'h0, 32'h0, 32'hFFFF_FFFF, 4'h0, lg);
    chk("cor log", 32'hFFFF_EE3E, cor_lg);
    wr(OFF_COR_MASK, 32'h0);
    $display("t_mask done");
  endtask : t_mask
  task automatic t_steer();
    logic [31:0] w, lg;
    logic [1:0] c;
    @(posedge clk);
    root_port_control <= 3'h7;
    for (int k = 0; k < 4; k++) begin
      w = 32'h4000;
      for (int i = 0; i < 6; i++) begin
        c = 2'(k + i);
        w |= 32'(c) << (i < 3 ? 12 - 2 * i : 10 - 2 * i);
      end
      wr(OFF_STEER, w);
      for (int i = 0; i < 6; i++) begin
        c = 2'(k + i);
        fire(6'h1 << i, 32'h0, 32'h0, 4'h1 << c, lg);
      end
    end
    wr(OFF_STEER, w & ~32'h4000);
    root_port_control <= 3'h0;
    for (int i = 0; i < 6; i++) begin
      fire(6'h1 << i, 32'h0, 32'h0, 4'h0, lg);
    end
    wr(OFF_STEER, 32'h0000_0024);
    root_port_control <= 3'h7;
    fire(6'h0, 32'h4000, 32'h0, 4'h4, lg);
    fire(6'h0, 32'h2000, 32'h0, 4'h2, lg);
    fire(6'h0, 32'h0, 32'h1, 4'h1, lg);
    wr(OFF_UNC_MASK, 32'h4000);
    fire(6'h0, 32'h4000, 32'h0, 4'h0, lg);
    wr(OFF_UNC_MASK, 32'h0);
    host_signal_enable <= 4'hB;
    fire(6'h0, 32'h4000, 32'h0, 4'h0, lg);
    host_signal_enable <= 4'hF;
    chk("sink count", 32'(exp_pulses), {16'h0, seen});
    $display("t_steer done");
  endtask : t_steer
  task automatic t_sticky();
    wr(OFF_UNC_MASK, 32'h0010_0010);
    wr(OFF_STEER, 32'h0001_C000);
    chk("unit ptr", 32'h1, {27'h0, unit_first_err_ptr});
    chk("hdr log en", 32'h1, {31'h0, hdr_log_lle_en});
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rchk("mask kept", OFF_UNC_MASK, 32'h0010_0010);
    rchk("steer after reset", OFF_STEER, 32'h0A01_0000);
    chk("unit ptr kept", 32'h1, {27'h0, unit_first_err_ptr});
    chk("hdr after reset", 32'h0, {31'h0, hdr_log_lle_en});
    resetn <= 1'b0;
    pwr_on_resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    pwr_on_resetn <= 1'b1;
    rchk("mask cleared", OFF_UNC_MASK, 32'h0);
    $display("t_sticky done");
  endtask : t_sticky
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    resetn = 1'b0;
    pwr_on_resetn = 1'b0;
    cfg_in = '0;
    be_cur = 4'hF;
    root_port_control = 3'h0;
    host_signal_enable = 4'hF;
    src = 6'h0;
    unc_err_detect = 32'h0;
    unc_err_fatal_sev = 32'h0000_4000;
    cor_err_detect = 32'h0;
    err_total = 0;
    checked = 0;
    exp_pulses = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    pwr_on_resetn <= 1'b1;
    t_reset();
    t_mask();
    t_steer();
    t_sticky();
    close_out();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #1000000;
    err_total++;
    close_out();
  end
endmodule : tb_pcie_error_steer_and_detect_mask
